// ==== dii_pkg.sv ====
// Constants, field layouts and carriers for the download information section builder
// What this block does
// R01: First byte of every section is the table identifier 0x3B.
// R02: Syntax and current/next bits are one; section version field is zero.
// R03: Section number and last section number are both 0x00.
// R04: Header carries discriminator 0x11, type 0x03, message id 0x1002, originator 10b.
// R05: Section length counts bytes from table-id extension through last CRC byte.
// R06: Table-id extension copies the low two bytes of the transaction identifier.
// R07: Transaction version subfield changes whenever any scenario message is updated.
// R08: Identification subfield is all zeros for a single-layer carousel.
// R09: Fields go out MSB first in the fixed message order.
// R10: Trailing CRC is MPEG-2 CRC-32 over table id through byte before CRC.
// R11: Update flag bit inverts every time the message content is updated.
// R12: Compatibility descriptor is only its length field, set to 0x0000.
// R13: Block size gives every block's data length; only a module's last is shorter.
// R14: Each module information byte is one ASCII character of the code file name.
package dii_pkg;

  localparam logic [7:0] DII_TABLE_ID = 8'h3B;
  localparam logic [7:0] DII_PROTO_DISC = 8'h11;
  localparam logic [7:0] DII_MSG_TYPE = 8'h03;
  localparam logic [15:0] DII_MSG_ID = 16'h1002;
  localparam logic [1:0] DII_ORIGINATOR = 2'h2;
  localparam logic [7:0] DII_SECT_NUM = 8'h00;
  localparam logic [4:0] DII_SECT_VERSION = 5'h00;
  localparam logic [7:0] DII_RESERVED_BYTE = 8'hFF;
  localparam logic [7:0] DII_ADAPT_LEN = 8'h00;
  localparam logic [7:0] DII_WINDOW_SIZE = 8'h00;
  localparam logic [7:0] DII_ACK_PERIOD = 8'h00;
  localparam logic [31:0] DII_TC_WINDOW = 32'h00000000;
  localparam logic [15:0] DII_COMPAT_LEN = 16'h0000;
  localparam logic [15:0] DII_PRIV_LEN = 16'h0000;
  localparam logic [31:0] DII_CRC_POLY = 32'h04C11DB7;
  localparam logic [31:0] DII_CRC_INIT = 32'hFFFFFFFF;
  // Byte counts of the fixed parts of the section
  localparam int DII_HDR_BYTES = 40;
  localparam int DII_ENTRY_HDR_BYTES = 8;
  localparam int DII_PRIV_BYTES = 2;
  localparam int DII_CRC_BYTES = 4;
  // Section length without module loop: 5 + 12 + 20 + 2 + 4
  localparam logic [11:0] DII_FIXED_SECT_LEN = 12'h02B;
  // Message length without module loop: 20 + 2
  localparam logic [15:0] DII_FIXED_MSG_LEN = 16'h0016;
  localparam logic [13:0] DII_TID_VERSION_RST = 14'h0000;

  typedef struct packed {
    logic [31:0] download_id;
    logic [15:0] block_size;
    logic [31:0] scenario_timeout;
    logic [15:0] num_modules;
    logic [14:0] identification;
    logic single_layer;
  } dii_cfg_t;

  typedef struct packed {
    logic [15:0] module_id;
    logic [31:0] module_size;
    logic [7:0] module_version;
    logic [7:0] info_len;
  } dii_entry_t;

  typedef struct packed {
    logic [7:0] data;
    logic last;
  } dii_byte_t;

  typedef enum logic [2:0] {
    DII_IDLE = 3'h0,
    DII_HDR = 3'h1,
    DII_MODS = 3'h3,
    DII_PRIV = 3'h2,
    DII_CRC = 3'h6
  } dii_state_t;

endpackage

// ==== dii_section_builder.sv ====
// Byte-serial builder of one download information section with module table and CRC
`timescale 1ns/1ps
module dii_section_builder #(
  parameter int MAX_MODULES = 4,
  parameter int NAME_MAX = 16
) (
  input wire logic clock,
  input wire logic rst,
  input dii_pkg::dii_cfg_t cfg,
  input wire logic start,
  output logic busy,
  input wire logic entry_wr,
  input wire logic [$clog2(MAX_MODULES)-1:0] entry_idx,
  input dii_pkg::dii_entry_t entry,
  input wire logic name_wr,
  input wire logic [$clog2(MAX_MODULES)-1:0] name_idx,
  input wire logic [$clog2(NAME_MAX)-1:0] name_pos,
  input wire logic [7:0] name_char,
  input wire logic scenario_update,
  input wire logic content_update,
  output logic out_valid,
  input wire logic out_ready,
  output dii_pkg::dii_byte_t out
);

  localparam int MI = $clog2(MAX_MODULES);
  localparam int NI = $clog2(NAME_MAX);
  localparam logic [7:0] NAME_MAX_B = 8'(NAME_MAX);
  localparam logic [15:0] MAX_MOD_W = 16'(MAX_MODULES);

  dii_pkg::dii_state_t state_ff;
  dii_pkg::dii_state_t nxt_state;
  dii_pkg::dii_cfg_t cfg_ff;
  dii_pkg::dii_entry_t table_ff [MAX_MODULES];
  logic [7:0] name_ff [MAX_MODULES][NAME_MAX];
  logic [13:0] tid_version_ff;
  logic update_flag_ff;
  logic [31:0] tid_ff;
  logic [8:0] sub_ff;
  logic [8:0] nxt_sub;
  logic [15:0] mod_ff;
  logic [15:0] nxt_mod;
  logic [31:0] crc_ff;
  logic vld_ff;
  dii_pkg::dii_byte_t out_ff;

  // Words of the outgoing section
  logic [15:0] nmod_eff;
  logic [11:0] loop_len;
  logic [11:0] sect_len;
  logic [15:0] msg_len;
  logic [31:0] tid_now;
  logic [319:0] hdr_vec;
  logic [63:0] ent_vec;
  dii_pkg::dii_entry_t cur_ent;
  logic [7:0] cur_byte;
  logic cur_last;
  logic advance;
  logic idle;
  logic hdr_end;
  logic ent_end;
  logic last_mod;
  logic priv_end;
  logic crc_end;
  logic [7:0] wr_len;

  // CRC-32, MSB first, no reflection and no final inversion
  function automatic logic [31:0] crc_step(input logic [31:0] c, input logic [7:0] d);
    logic [31:0] r;
    logic fb;
    r = c;
    for (int i = 7; i >= 0; i--)
    begin
      fb = r[31] ^ d[i];
      r = {r[30:0], 1'b0} ^ (fb ? dii_pkg::DII_CRC_POLY : 32'h00000000);
    end
    return r;
  endfunction

  // Module count is clipped to the table depth so the loop never walks off it
  assign nmod_eff = (cfg_ff.num_modules > MAX_MOD_W) ? MAX_MOD_W : cfg_ff.num_modules;

  // Length of the module loop: fixed entry header plus name characters each
  always_comb
  begin
    loop_len = 12'h000;
    for (int i = 0; i < MAX_MODULES; i++)
    begin
      if (16'(i) < nmod_eff)
      begin
        loop_len = loop_len + 12'(dii_pkg::DII_ENTRY_HDR_BYTES) + {4'h0, table_ff[i].info_len};
      end
    end
  end

  assign sect_len = dii_pkg::DII_FIXED_SECT_LEN + loop_len; // R05
  assign msg_len = dii_pkg::DII_FIXED_MSG_LEN + {4'h0, loop_len};

  // Transaction identifier: originator, version, identification, update flag
  assign tid_now = {dii_pkg::DII_ORIGINATOR, tid_version_ff, // R04
                    cfg.single_layer ? 15'h0000 : cfg.identification, // R08
                    update_flag_ff};

  // Fixed part of the section, MSB first, one flat vector to index by byte
  assign hdr_vec = {
    dii_pkg::DII_TABLE_ID, // R01
    1'b1, 3'h7, sect_len, // R02 R05
    tid_ff[15:0], // R06
    2'h3, dii_pkg::DII_SECT_VERSION, 1'b1, // R02
    dii_pkg::DII_SECT_NUM, dii_pkg::DII_SECT_NUM, // R03
    dii_pkg::DII_PROTO_DISC, dii_pkg::DII_MSG_TYPE, dii_pkg::DII_MSG_ID, // R04
    tid_ff,
    dii_pkg::DII_RESERVED_BYTE, dii_pkg::DII_ADAPT_LEN, msg_len,
    cfg_ff.download_id, cfg_ff.block_size, // R09 R13
    dii_pkg::DII_WINDOW_SIZE, dii_pkg::DII_ACK_PERIOD, dii_pkg::DII_TC_WINDOW,
    cfg_ff.scenario_timeout,
    dii_pkg::DII_COMPAT_LEN, // R12
    nmod_eff
  };

  assign cur_ent = table_ff[mod_ff[MI-1:0]];
  assign ent_vec = cur_ent;

  // Byte under the cursor for each part of the section
  always_comb
  begin
    cur_byte = 8'h00;
    case (state_ff)
      dii_pkg::DII_HDR:
        cur_byte = hdr_vec[8 * (dii_pkg::DII_HDR_BYTES - 1 - int'(sub_ff)) +: 8]; // R09
      dii_pkg::DII_MODS:
        if (int'(sub_ff) < dii_pkg::DII_ENTRY_HDR_BYTES)
        begin
          cur_byte = ent_vec[8 * (dii_pkg::DII_ENTRY_HDR_BYTES - 1 - int'(sub_ff)) +: 8];
        end
        else
        begin
          cur_byte = name_ff[mod_ff[MI-1:0]][NI'(sub_ff - 9'(dii_pkg::DII_ENTRY_HDR_BYTES))]; // R14
        end
      dii_pkg::DII_PRIV:
        cur_byte = sub_ff[0] ? dii_pkg::DII_PRIV_LEN[7:0] : dii_pkg::DII_PRIV_LEN[15:8];
      dii_pkg::DII_CRC:
        cur_byte = crc_ff[8 * (dii_pkg::DII_CRC_BYTES - 1 - int'(sub_ff)) +: 8]; // R10
      default:
        cur_byte = 8'h00;
    endcase
  end

  // Boundary decodes
  assign idle = (state_ff == dii_pkg::DII_IDLE);
  assign advance = !idle && (!vld_ff || out_ready);
  assign hdr_end = (int'(sub_ff) == dii_pkg::DII_HDR_BYTES - 1);
  assign ent_end = (sub_ff == 9'(dii_pkg::DII_ENTRY_HDR_BYTES - 1) + {1'b0, cur_ent.info_len});
  assign last_mod = (mod_ff + 16'h0001 == nmod_eff);
  assign priv_end = (int'(sub_ff) == dii_pkg::DII_PRIV_BYTES - 1);
  assign crc_end = (int'(sub_ff) == dii_pkg::DII_CRC_BYTES - 1);
  assign cur_last = (state_ff == dii_pkg::DII_CRC) && crc_end;
  assign wr_len = (entry.info_len > NAME_MAX_B) ? NAME_MAX_B : entry.info_len;

  // Sequencer: header, module loop, private data length, CRC
  always_comb
  begin
    nxt_state = state_ff;
    nxt_sub = sub_ff;
    nxt_mod = mod_ff;
    case (state_ff)
      dii_pkg::DII_IDLE:
        if (start)
        begin
          nxt_state = dii_pkg::DII_HDR;
          nxt_sub = 9'h000;
        end
      dii_pkg::DII_HDR:
        if (advance)
        begin
          nxt_sub = hdr_end ? 9'h000 : sub_ff + 9'h001;
          nxt_mod = 16'h0000;
          if (hdr_end)
          begin
            nxt_state = (nmod_eff == 16'h0000) ? dii_pkg::DII_PRIV : dii_pkg::DII_MODS;
          end
        end
      dii_pkg::DII_MODS:
        if (advance)
        begin
          nxt_sub = ent_end ? 9'h000 : sub_ff + 9'h001;
          if (ent_end && last_mod)
          begin
            nxt_state = dii_pkg::DII_PRIV;
          end
          else if (ent_end)
          begin
            nxt_mod = mod_ff + 16'h0001;
          end
        end
      dii_pkg::DII_PRIV:
        if (advance)
        begin
          nxt_sub = priv_end ? 9'h000 : sub_ff + 9'h001;
          nxt_state = priv_end ? dii_pkg::DII_CRC : dii_pkg::DII_PRIV;
        end
      dii_pkg::DII_CRC:
        if (advance)
        begin
          nxt_sub = crc_end ? 9'h000 : sub_ff + 9'h001;
          nxt_state = crc_end ? dii_pkg::DII_IDLE : dii_pkg::DII_CRC;
        end
      default:
        nxt_state = dii_pkg::DII_IDLE;
    endcase
  end

  // State, cursor and frame snapshot; config is frozen so lengths cannot shift mid-frame
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      state_ff <= dii_pkg::DII_IDLE;
      sub_ff <= 9'h000;
      mod_ff <= 16'h0000;
      cfg_ff <= '0;
      tid_ff <= 32'h00000000;
    end
    else
    begin
      state_ff <= nxt_state;
      sub_ff <= nxt_sub;
      mod_ff <= nxt_mod;
      if (idle && start)
      begin
        cfg_ff <= cfg;
        tid_ff <= tid_now;
      end
    end
  end

  // Version moves on any scenario update; flag inverts on each content update
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      tid_version_ff <= dii_pkg::DII_TID_VERSION_RST;
      update_flag_ff <= 1'b0;
    end
    else
    begin
      if (scenario_update || content_update)
      begin
        tid_version_ff <= tid_version_ff + 14'h0001; // R07
      end
      if (content_update)
      begin
        update_flag_ff <= ~update_flag_ff; // R11
      end
    end
  end

  // Module table and names; writes while a section is out are dropped
  always_ff @(posedge clock)
  begin
    if (entry_wr && idle)
    begin
      table_ff[entry_idx] <= '{entry.module_id, entry.module_size, entry.module_version, wr_len};
    end
    if (name_wr && idle)
    begin
      name_ff[name_idx][name_pos] <= name_char; // R14
    end
  end

  // Output register and running CRC over every byte before the CRC itself
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      vld_ff <= 1'b0;
      out_ff <= '0;
      crc_ff <= dii_pkg::DII_CRC_INIT;
    end
    else
    begin
      if (idle && start)
      begin
        crc_ff <= dii_pkg::DII_CRC_INIT;
      end
      else if (advance && state_ff != dii_pkg::DII_CRC)
      begin
        crc_ff <= crc_step(crc_ff, cur_byte); // R10
      end
      if (advance)
      begin
        vld_ff <= 1'b1;
        out_ff <= '{cur_byte, cur_last};
      end
      else if (out_ready)
      begin
        vld_ff <= 1'b0;
      end
    end
  end

  assign out_valid = vld_ff;
  assign out = out_ff;
  assign busy = !idle || vld_ff;

endmodule

// ==== dii_chk.sv ====
// Concurrent checks on the section byte stream
`timescale 1ns/1ps
module dii_chk (
  input wire logic clock,
  input wire logic rst,
  input wire logic start,
  input wire logic busy,
  input wire logic out_valid,
  input wire logic out_ready,
  input dii_pkg::dii_byte_t out
);
  logic [11:0] idx_ff;
  logic [11:0] len_ff;
  logic [15:0] tie_ff;
  wire logic take = out_valid && out_ready;
  wire logic [7:0] d = out.data;
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  // Byte position in the section, so each field is judged where it lands
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      idx_ff <= 12'h000;
      len_ff <= 12'h000;
      tie_ff <= 16'h0000;
    end
    else if (take)
    begin
      idx_ff <= out.last ? 12'h000 : idx_ff + 12'h001;
      if (idx_ff == 12'h001)
        len_ff[11:8] <= d[3:0];
      if (idx_ff == 12'h002)
        len_ff[7:0] <= d;
      if (idx_ff == 12'h003)
        tie_ff[15:8] <= d;
      if (idx_ff == 12'h004)
        tie_ff[7:0] <= d;
    end
  end
  // An idle start must show the first byte two edges later
  sequence s_idle_start;
    start && !busy;
  endsequence
  sequence s_first_byte;
    out_valid && d == 8'h3B;
  endsequence
  AST_LAT: assert property (s_idle_start |-> ##2 s_first_byte) else $error("late first byte");
  AST_TABLE_ID: assert property (out_valid && idx_ff == 12'h000 |-> d == 8'h3B) else $error("bad table id");
  AST_CNI: assert property (out_valid && idx_ff == 12'h005 |-> d == 8'hC1) else $error("bad version byte");
  AST_SECT_NUM: assert property (out_valid && idx_ff inside {12'h006, 12'h007} |-> d == 8'h00) else $error("bad sect");
  AST_MSG_HDR: assert property (out_valid && idx_ff inside {[12'h008:12'h00B]} |->
    d == (idx_ff[1] ? (idx_ff[0] ? 8'h02 : 8'h10) : (idx_ff[0] ? 8'h03 : 8'h11))) else $error("bad msg header");
  AST_TIE: assert property (out_valid && idx_ff inside {12'h00E, 12'h00F} |->
    d == (idx_ff[0] ? tie_ff[7:0] : tie_ff[15:8])) else $error("bad extension");
  AST_ZERO: assert property (out_valid && idx_ff inside {[12'h01A:12'h01F], 12'h024, 12'h025} |-> d == 8'h00)
    else $error("nonzero fixed field");
  AST_LEN: assert property (out_valid && out.last |-> idx_ff == len_ff + 12'h002) else $error("bad length");
  AST_HOLD: assert property (out_valid && !out_ready |=> out_valid && $stable(out)) else $error("byte dropped");
endmodule

// ==== dii_host.sv ====
// Receiving host model: takes section bytes and counts the sections whose CRC checks
`timescale 1ns/1ps
module dii_host (
  input wire logic clock,
  input wire logic rst,
  input wire logic slow,
  input wire logic out_valid,
  input dii_pkg::dii_byte_t out,
  output logic out_ready
);
  logic [7:0] buf_ff [0:255];
  logic [7:0] n_ff;
  logic [8:0] len_ff;
  logic [7:0] good_ff;
  logic [31:0] crc_ff;
  logic [31:0] nxt_crc;
  // MSB first; over a whole good section the residue is zero
  always_comb
  begin
    nxt_crc = crc_ff;
    for (int i = 7; i >= 0; i--)
      nxt_crc = {nxt_crc[30:0], 1'b0} ^ ((nxt_crc[31] ^ out.data[i]) ? 32'h04C11DB7 : 32'h00000000);
  end
  // Slow mode accepts every other cycle so the source has to hold
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      out_ready <= 1'b1;
      n_ff <= 8'h00;
      len_ff <= 9'h000;
      good_ff <= 8'h00;
      crc_ff <= 32'hFFFFFFFF;
    end
    else
    begin
      out_ready <= slow ? ~out_ready : 1'b1;
      if (out_valid && out_ready)
      begin
        buf_ff[n_ff] <= out.data;
        n_ff <= out.last ? 8'h00 : n_ff + 8'h01;
        crc_ff <= out.last ? 32'hFFFFFFFF : nxt_crc;
        if (out.last)
          len_ff <= {1'b0, n_ff} + 9'h001;
        if (out.last && nxt_crc == 32'h00000000)
          good_ff <= good_ff + 8'h01;
      end
    end
  end
endmodule

// ==== tb.sv ====
// Self-checking bench for the download information section builder
`timescale 1ns/1ps
module tb;
  logic clock;
  logic rst;
  dii_pkg::dii_cfg_t cfg;
  logic start;
  logic busy;
  logic entry_wr;
  logic [1:0] entry_idx;
  dii_pkg::dii_entry_t entry;
  logic name_wr;
  logic [1:0] name_idx;
  logic [3:0] name_pos;
  logic [7:0] name_char;
  logic scenario_update;
  logic content_update;
  logic out_valid;
  logic out_ready;
  dii_pkg::dii_byte_t out;
  logic slow;
  logic [13:0] ver;
  logic flag;
  int n_errors;
  int n_compared;
  logic [7:0] ex[$];
  dii_pkg::dii_entry_t ent [0:3];
  logic [7:0] nm [0:3][0:15];
  dii_section_builder dii_section_builder_inst (.clock, .rst, .cfg, .start, .busy, .entry_wr, .entry_idx, .entry,
    .name_wr, .name_idx, .name_pos, .name_char, .scenario_update, .content_update, .out_valid, .out_ready, .out);
  dii_host dii_host_inst (.clock, .rst, .slow, .out_valid, .out, .out_ready);
  // 200 MHz
  initial
  begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  task automatic end_of_test();
    $display("errors %0d compared %0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] want);
    n_compared++;
    if (seen !== want)
    begin
      n_errors++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, want);
    end
  endtask
  task automatic put(input logic [63:0] v, input int n);
    for (int i = n - 1; i >= 0; i--)
      ex.push_back(v[8 * i +: 8]);
  endtask
  // Table entry first, then its name one character per cycle
  task automatic load(input int k, input dii_pkg::dii_entry_t e, input string s);
    ent[k] = e;
    @(posedge clock);
    entry_wr <= 1'b1;
    entry_idx <= k[1:0];
    entry <= e;
    name_idx <= k[1:0];
    for (int i = 0; i < s.len(); i++)
    begin
      nm[k][i] = s[i];
      @(posedge clock);
      entry_wr <= 1'b0;
      name_wr <= 1'b1;
      name_pos <= i[3:0];
      name_char <= s[i];
    end
    @(posedge clock);
    entry_wr <= 1'b0;
    name_wr <= 1'b0;
  endtask
  task automatic upd(input logic sc, input logic cu);
    @(posedge clock);
    scenario_update <= sc;
    content_update <= cu;
    @(posedge clock);
    scenario_update <= 1'b0;
    content_update <= 1'b0;
    ver = ver + 14'h0001;
    flag = flag ^ cu;
  endtask
  // One section; a second start mid-section must be ignored
  task automatic frame(input logic again);
    logic [31:0] tid;
    logic [11:0] ml;
    logic [7:0] g0;
    // Let a config change made just before the call land before it is read
    @(posedge clock);
    ml = 12'h000;
    for (int k = 0; k < cfg.num_modules; k++)
      ml += 12'h008 + ent[k].info_len;
    tid = {2'b10, ver, cfg.single_layer ? 15'h0000 : cfg.identification, flag};
    ex.delete();
    put({8'h3B, 4'hF, ml + 12'h02B, tid[15:0], 8'hC1, 16'h0000}, 8);
    put({32'h11031002, tid}, 8);
    put({16'hFF00, ml + 16'h0016, cfg.download_id}, 8);
    put({cfg.block_size, 16'h0000, 32'h00000000}, 8);
    put({cfg.scenario_timeout, 16'h0000, cfg.num_modules}, 8);
    for (int k = 0; k < cfg.num_modules; k++)
    begin
      put(ent[k], 8);
      for (int i = 0; i < ent[k].info_len; i++)
        put(nm[k][i], 1);
    end
    put(16'h0000, 2);
    g0 = dii_host_inst.good_ff;
    @(posedge clock);
    start <= 1'b1;
    @(posedge clock);
    start <= 1'b0;
    repeat (8) @(posedge clock);
    chk(busy, 1'b1);
    start <= again;
    @(posedge clock);
    start <= 1'b0;
    for (int i = 0; i < 3000 && dii_host_inst.good_ff == g0; i++)
      @(posedge clock);
    chk(dii_host_inst.good_ff, g0 + 8'h01);
    chk(dii_host_inst.len_ff, ex.size() + 4);
    for (int i = 0; i < ex.size(); i++)
      chk(dii_host_inst.buf_ff[i], ex[i]);
    repeat (4) @(posedge clock);
    chk(out_valid, 1'b0);
    chk(busy, 1'b0);
  endtask
  task automatic t_basic();
    @(posedge clock);
    cfg <= '{32'h12345678, 16'h0400, 32'h000F4240, 16'h0002, 15'h1234, 1'b1};
    load(0, '{16'h0001, 32'h00010000, 8'h01, 8'h03}, "abc");
    load(1, '{16'h0002, 32'h00000010, 8'h02, 8'h00}, "");
    frame(1'b0);
  endtask
  // Version and flag updates, multi-layer id, slow host and ignored start
  task automatic t_update();
    upd(1'b1, 1'b0);
    upd(1'b0, 1'b1);
    upd(1'b1, 1'b1);
    @(posedge clock);
    slow <= 1'b1;
    cfg <= '{32'hFFFFFFFF, 16'hFFFF, 32'h00000001, 16'h0000, 15'h7FFF, 1'b0};
    frame(1'b1);
    slow <= 1'b0;
  endtask
  // Full table with a name of the largest length
  task automatic t_full();
    load(2, '{16'hFFFF, 32'hFFFFFFFF, 8'hFF, 8'h10}, "code_file_name16");
    load(3, '{16'h0004, 32'h00000001, 8'h00, 8'h01}, "x");
    @(posedge clock);
    cfg.num_modules <= 16'h0004;
    frame(1'b0);
  endtask
  initial
  begin
    rst = 1'b1;
    cfg = '0;
    start = 1'b0;
    entry_wr = 1'b0;
    entry_idx = 2'h0;
    entry = '0;
    name_wr = 1'b0;
    name_idx = 2'h0;
    name_pos = 4'h0;
    name_char = 8'h00;
    scenario_update = 1'b0;
    content_update = 1'b0;
    slow = 1'b0;
    ver = 14'h0000;
    flag = 1'b0;
    repeat (10) @(posedge clock);
    rst <= 1'b0;
    t_basic();
    t_update();
    t_full();
    end_of_test();
  end
  // Three sections need well under a thousand cycles
  initial
  begin
    repeat (20000) @(posedge clock);
    n_errors++;
    end_of_test();
  end
endmodule
bind dii_section_builder dii_chk dii_chk_inst (.clock, .rst, .start, .busy, .out_valid, .out_ready, .out);
